// file: common/io_ports_pkg.sv
/* Constants for the multiplexed I/O port block: APB offsets, per-pin masks,
   reset values and the positions of pins with peripheral functions.
   Assumes a 32-bit APB slave on pclk with asynchronous active-low reset. */
// What this block does
// - Each pin is input or output by its own direction bit.
// - Where a port has pull-ups, a set pull-up bit enables that pin's pull-up while the pin is a digital input.
// - Each pin with a peripheral function chooses port use or that function by its own bit.
// - Port widths are 2, 8, 8, 4, 2, 4, 6 and 5 bits.
// - After reset all eight analog-capable pins stay analog until software changes them.
// - The four open-drain pins only pull low and never drive high.
// - The last port has a pull-up control on bit 0 only.
// - Each external interrupt pin detects rising, falling or both edges by selection.
// - Key interrupt function exists only on bits 0 to 3 of the key port.
// - Timer pin A counts and triggers both captures; pin B triggers capture A only.
package io_ports_pkg;

  // Pins are flat: slot*8+bit; slots hold the ports in order of appearance.
  localparam int NSLOT = 8;
  localparam int NPIN  = 64;
  localparam int NEXT  = 6;
  localparam int NKEY  = 4;
  localparam int NEVT  = 10;

  // Implemented pins, pull-up capable pins and pins with a peripheral function.
  localparam logic [63:0] PIN_MASK  = 64'h1f3f_0f03_0fff_ff03;
  localparam logic [63:0] PULL_MASK = 64'h013f_0003_0f00_ff03;
  localparam logic [63:0] ALT_MASK  = 64'h1f0f_0f00_0fff_ff03;

  // Slots with special pad behaviour.
  localparam logic [2:0] SLOT_ANALOG = 3'h2;
  localparam logic [2:0] SLOT_OD     = 3'h5;

  // Pin positions of peripheral functions.
  localparam int PIN_TMR_A = 0;
  localparam int PIN_TMR_B = 1;
  localparam int PIN_2W_CK = 42;
  localparam int PIN_KEY0  = 48;
  localparam int EXT_PIN [NEXT] = '{56, 24, 25, 26, 27, 14};

  // Reset values.
  localparam logic [63:0] DIR_RST   = PIN_MASK;
  localparam logic [63:0] ALT_RST   = 64'h0000_0000_00ff_0000;
  localparam logic [11:0] EDGE_RST  = 12'h000;
  localparam logic [NEVT-1:0] EVT_RST = 10'h000;

  // Register addresses: port block at slot*16 + sub*4.
  localparam logic [3:0]  PAGE_PORT  = 4'h0;
  localparam logic [3:0]  PAGE_LEVEL = 4'h1;
  localparam logic [1:0]  SUB_LATCH  = 2'h0;
  localparam logic [1:0]  SUB_DIR    = 2'h1;
  localparam logic [1:0]  SUB_PULL   = 2'h2;
  localparam logic [1:0]  SUB_ALT    = 2'h3;
  localparam logic [11:0] ADDR_EDGE  = 12'h200;
  localparam logic [11:0] ADDR_STAT  = 12'h204;
  localparam logic [11:0] ADDR_MASK  = 12'h208;

  // Edge selection codes, two bits per external interrupt pin.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [3:0] {
    K_LATCH, K_DIR, K_PULL, K_ALT, K_LEVEL, K_EDGE, K_STAT, K_MASK, K_NONE
  } reg_kind_e;

endpackage

// file: logic/pin_sync.sv
/* Two flip-flop synchroniser for a vector of pad inputs.
   Assumes the inputs are asynchronous to pclk; the output is safe to use. */
`timescale 1ns/100ps
module pin_sync
  import io_ports_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage is read only by the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// file: logic/edge_detect.sv
/* Selectable edge detector giving a one-cycle pulse.
   Assumes a level already synchronised to pclk. */
`timescale 1ns/100ps
module edge_detect
  import io_ports_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       level,
  input  wire logic       enable,
  input  wire logic [1:0] edge_sel,
  output logic            pulse
);

  logic prev;
  logic armed;
  logic rise_on;
  logic fall_on;

  // The first cycle after reset only loads the history, so no false edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev  <= 1'b0;
      armed <= 1'b0;
    end else begin
      prev  <= level;
      armed <= 1'b1;
    end
  end

  // Rising, falling or both edges as selected.
  assign rise_on = (edge_sel == EDGE_RISE) || (edge_sel == EDGE_BOTH);
  assign fall_on = (edge_sel == EDGE_FALL) || (edge_sel == EDGE_BOTH);
  assign pulse   = enable & armed & ((rise_on & level & ~prev) | (fall_on & ~level & prev));

endmodule

// file: logic/multiplexed_io_ports.sv
/* Multiplexed I/O ports: direction, output latch, pull-up and function
   select per pin, pad muxing, timer and interrupt inputs, APB registers.
   Assumes pads resolve level from pad_out/pad_oe and pull-ups from
   pad_pullup; peripherals drive alt_out/alt_oe and read periph_in. */
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/100ps
module multiplexed_io_ports
  import io_ports_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [63:0]     pad_in,
  output logic      [63:0]     pad_out,
  output logic      [63:0]     pad_oe,
  output logic      [63:0]     pad_pullup,
  output logic      [7:0]      analog_en,
  input  wire logic [63:0]     alt_out,
  input  wire logic [63:0]     alt_oe,
  output logic      [63:0]     periph_in,
  output logic                 timer16_count_capture_in,
  output logic                 timer16_capture_in,
  output logic                 timer16_count_pulse,
  output logic                 timer16_capture_a_trig,
  output logic                 timer16_capture_b_trig,
  output logic      [NEXT-1:0] ext_irq_evt,
  output logic      [NKEY-1:0] key_irq_evt,
  output logic                 twowire_ext_clock_in,
  output logic                 irq
);

  logic [63:0]     latch;
  logic [63:0]     dir;
  logic [63:0]     pull;
  logic [63:0]     alt;
  logic [63:0]     pin_s;
  logic [63:0]     analog;
  logic [63:0]     next_out;
  logic [63:0]     next_oe;
  logic [11:0]     edge_sel;
  logic [NEVT-1:0] status;
  logic [NEVT-1:0] mask;
  logic [NEVT-1:0] evt;
  logic [NEVT-1:0] next_status;
  reg_kind_e       kind;
  logic [2:0]      slot;
  logic [5:0]      base;
  logic [31:0]     rd_val;
  logic            wr;
  logic            setup;

  // Address decoding into register kind and port slot.
  always_comb begin
    slot = paddr[6:4];
    kind = K_NONE;
    if (paddr[11:8] == PAGE_PORT && !paddr[7]) begin
      case (paddr[3:2])
        SUB_LATCH: kind = K_LATCH;
        SUB_DIR:   kind = K_DIR;
        SUB_PULL:  kind = K_PULL;
        default:   kind = K_ALT;
      endcase
    end else if (paddr[11:8] == PAGE_LEVEL && paddr[7:5] == 3'h0) begin
      kind = K_LEVEL;
      slot = paddr[4:2];
    end else if (paddr == ADDR_EDGE) begin
      kind = K_EDGE;
    end else if (paddr == ADDR_STAT) begin
      kind = K_STAT;
    end else if (paddr == ADDR_MASK) begin
      kind = K_MASK;
    end
  end

  assign base  = {slot, 3'h0};
  assign wr    = psel & penable & pwrite & (kind != K_NONE);
  assign setup = psel & ~penable;

  // Read data mux; reserved and unimplemented bits read as zero.
  always_comb begin
    rd_val = 32'h0000_0000;
    case (kind)
      K_LATCH: rd_val[7:0] = latch[base +: 8];
      K_DIR:   rd_val[7:0] = dir[base +: 8];
      K_PULL:  rd_val[7:0] = pull[base +: 8];
      K_ALT:   rd_val[7:0] = alt[base +: 8];
      K_LEVEL: rd_val[7:0] = pin_s[base +: 8] & PIN_MASK[base +: 8] & ~analog[base +: 8];
      K_EDGE:  rd_val[11:0] = edge_sel;
      K_STAT:  rd_val[NEVT-1:0] = status;
      K_MASK:  rd_val[NEVT-1:0] = mask;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data and error are captured in the setup cycle; no wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= (kind == K_NONE);
    end
  end

  assign pready = 1'b1;

  // Output latches; bits without a pin stay zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= 64'h0;
    end else if (wr && kind == K_LATCH) begin
      latch[base +: 8] <= pwdata[7:0] & PIN_MASK[base +: 8];
    end
  end

  // Direction per pin, one means input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= DIR_RST;
    end else if (wr && kind == K_DIR) begin
      dir[base +: 8] <= pwdata[7:0] & PIN_MASK[base +: 8];
    end
  end

  // Pull-up enables exist only where the pin has a pull-up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull <= 64'h0;
    end else if (wr && kind == K_PULL) begin
      pull[base +: 8] <= pwdata[7:0] & PULL_MASK[base +: 8];
    end
  end

  // Function select per pin; analog pins start in analog mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt <= ALT_RST;
    end else if (wr && kind == K_ALT) begin
      alt[base +: 8] <= pwdata[7:0] & ALT_MASK[base +: 8];
    end
  end

  // Edge selections for the external interrupt pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel <= EDGE_RST;
    end else if (wr && kind == K_EDGE) begin
      edge_sel <= pwdata[11:0];
    end
  end

  // Interrupt mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= EVT_RST;
    end else if (wr && kind == K_MASK) begin
      mask <= pwdata[NEVT-1:0];
    end
  end

  // Sticky status, write one to clear; a new event beats the clear.
  always_comb begin
    next_status = status;
    if (wr && kind == K_STAT) begin
      next_status = status & ~pwdata[NEVT-1:0];
    end
    next_status = next_status | evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= EVT_RST;
    end else begin
      status <= next_status;
    end
  end

  assign irq = |(status & mask);

  // All pad inputs are synchronised before use.
  pin_sync #(
    .W (NPIN)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pad_in),
    .q       (pin_s)
  );

  // Pad muxing per pin: port latch or peripheral, open drain, analog.
  for (genvar i = 0; i < NPIN; i++) begin : g_pad
    if (i / 8 == int'(SLOT_ANALOG)) begin : g_an
      assign analog[i]   = alt[i];
      assign next_out[i] = latch[i];
      assign next_oe[i]  = ~alt[i] & ~dir[i];
    end else if (i / 8 == int'(SLOT_OD)) begin : g_od
      assign analog[i]   = 1'b0;
      assign next_out[i] = 1'b0;
      assign next_oe[i]  = (alt[i] ? (alt_oe[i] & ~alt_out[i]) : (~dir[i] & ~latch[i])) &
                           PIN_MASK[i];
    end else begin : g_pp
      assign analog[i]   = 1'b0;
      assign next_out[i] = alt[i] ? alt_out[i] : latch[i];
      assign next_oe[i]  = (alt[i] ? alt_oe[i] : ~dir[i]) & PIN_MASK[i];
    end
  end

  // Pad drive is registered; pull-ups act on digital inputs only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 64'h0;
      pad_oe  <= 64'h0;
    end else begin
      pad_out <= next_out;
      pad_oe  <= next_oe;
    end
  end

  assign pad_pullup = pull & dir & ~analog & PULL_MASK;
  assign analog_en  = analog[16 +: 8];
  assign periph_in  = pin_s & PIN_MASK & ~analog;

  // Peripheral input levels.
  assign timer16_count_capture_in = periph_in[PIN_TMR_A];
  assign timer16_capture_in       = periph_in[PIN_TMR_B];
  assign twowire_ext_clock_in     = periph_in[PIN_2W_CK];

  logic tmr_a_rise;
  logic tmr_b_rise;

  // Timer pin A counts and captures into both; pin B into capture A only.
  edge_detect u_tmr_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .level    (pin_s[PIN_TMR_A]),
    .enable   (alt[PIN_TMR_A]),
    .edge_sel (EDGE_RISE),
    .pulse    (tmr_a_rise)
  );

  edge_detect u_tmr_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .level    (pin_s[PIN_TMR_B]),
    .enable   (alt[PIN_TMR_B]),
    .edge_sel (EDGE_RISE),
    .pulse    (tmr_b_rise)
  );

  assign timer16_count_pulse    = tmr_a_rise;
  assign timer16_capture_a_trig = tmr_a_rise | tmr_b_rise;
  assign timer16_capture_b_trig = tmr_a_rise;

  // External interrupt pins with selectable edges.
  for (genvar k = 0; k < NEXT; k++) begin : g_ext
    edge_detect u_ext (
      .pclk     (pclk),
      .presetn  (presetn),
      .level    (pin_s[EXT_PIN[k]]),
      .enable   (alt[EXT_PIN[k]]),
      .edge_sel (edge_sel[2*k +: 2]),
      .pulse    (ext_irq_evt[k])
    );
  end

  // Key interrupt pins fire on a falling edge.
  for (genvar k = 0; k < NKEY; k++) begin : g_key
    edge_detect u_key (
      .pclk     (pclk),
      .presetn  (presetn),
      .level    (pin_s[PIN_KEY0+k]),
      .enable   (alt[PIN_KEY0+k]),
      .edge_sel (EDGE_FALL),
      .pulse    (key_irq_evt[k])
    );
  end

  assign evt = {key_irq_evt, ext_irq_evt};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A direction write lands in the addressed slot one edge later.
  sequence s_dir_wr;
    wr && kind == K_DIR;
  endsequence
  property p_dir_wr;
    s_dir_wr |=> dir[$past(base) +: 8] == ($past(pwdata[7:0]) & PIN_MASK[$past(base) +: 8]);
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction write lost");

  property p_pull_input;
    pull[8] && dir[8] |-> pad_pullup[8];
  endproperty
  a_pull_input: assert property (p_pull_input) else $error("pull-up not applied");

  property p_alt_drive;
    alt[PIN_TMR_B] |=> pad_out[PIN_TMR_B] == $past(alt_out[PIN_TMR_B]);
  endproperty
  a_alt_drive: assert property (p_alt_drive) else $error("alternate output not muxed");

  property p_width;
    ((latch | dir | alt | pad_oe) & ~PIN_MASK) == 64'h0;
  endproperty
  a_width: assert property (p_width) else $error("bit beyond port width");

  property p_analog_rst;
    $rose(presetn) |-> analog_en == 8'hff ##1 (analog_en == 8'hff || $past(wr));
  endproperty
  a_analog_rst: assert property (p_analog_rst) else $error("analog mode lost at reset");

  property p_open_drain;
    (pad_out[47:40] == 8'h00) and (!alt[40] && !dir[40] && latch[40] |=> !pad_oe[40]);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain driven high");

  property p_pull_mask;
    pad_pullup[63:57] == 7'h0 && pad_pullup[23:16] == 8'h0 && pad_pullup[47:40] == 8'h0;
  endproperty
  a_pull_mask: assert property (p_pull_mask) else $error("pull-up on bare pin");

  property p_ext_rise;
    ext_irq_evt[1] && edge_sel[3:2] == EDGE_RISE |-> pin_s[24] && !$past(pin_s[24]);
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("wrong edge accepted");

  property p_key_bits;
    (alt[53:52] == 2'h0) and (key_irq_evt[0] |=> status[NEXT]);
  endproperty
  a_key_bits: assert property (p_key_bits) else $error("key event misplaced");

  property p_capture;
    timer16_capture_b_trig |-> timer16_capture_a_trig && timer16_count_pulse;
  endproperty
  a_capture: assert property (p_capture) else $error("capture trigger mismatch");

endmodule

// file: testbench/io_board_model.sv
/* Board model for the I/O port block: resolves each pad from the block's
   drive, the board's own drivers, pull-ups and a two-wire clock source.
   Assumes the flat pin order slot*8+bit of the port package. */
`timescale 1ns/100ps
module io_board_model
  import io_ports_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [63:0] pad_out,
  input  wire logic [63:0] pad_oe,
  input  wire logic [63:0] pad_pullup,
  input  wire logic [63:0] ext_val,
  input  wire logic [63:0] ext_en,
  input  wire logic        ck_en,
  output logic      [63:0] pad_in
);
  logic float_pat = 1'b0;
  logic ck_2w     = 1'b0;

  // A pad nobody drives shows a level that changes every cycle.
  always @(posedge pclk) begin
    float_pat <= ~float_pat;
  end

  // External two-wire clock at 6.4 MHz; it stands low while disabled.
  always begin
    #78.1 ck_2w = ck_en ? ~ck_2w : 1'b0;
  end

  // Open-drain pads only pull low and are pulled up on the board.
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (pad_oe[i])
        pad_in[i] = (i / 8 == int'(SLOT_OD)) ? 1'b0 : pad_out[i];
      else if (ck_en && i == PIN_2W_CK)
        pad_in[i] = ck_2w;
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pullup[i] || i / 8 == int'(SLOT_OD))
        pad_in[i] = 1'b1;
      else
        pad_in[i] = float_pat;
    end
  end
endmodule

// file: testbench/tb_top.sv
/* Self-checking bench for the multiplexed I/O port block: register traffic,
   pad drive, pull-ups, pin levels, edge events and timer triggers.
   Assumes the board model and the constants of the port package. */
`timescale 1ns/100ps
module tb_top
  import io_ports_pkg::*;
;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, r;
  logic [63:0]     pad_in, pad_out, pad_oe, pad_pullup, alt_out, alt_oe, periph_in;
  logic [63:0]     ext_val, ext_en, got, ex, v, ev;
  logic [7:0]      analog_en, cnt_a, cnt_b, cnt_n;
  logic [NEXT-1:0] ext_evt;
  logic [NKEY-1:0] key_evt;
  logic            t_cc, t_c, t_cnt, t_a, t_b, tw_ck, ck_en, probe, cnt_clr, tw_hi;
  logic [1:0]      code;
  int              probe_sel, fail_count, samples_checked;
  logic [63:0]     exp_q[$];

  multiplexed_io_ports u_multiplexed_io_ports (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup(pad_pullup), .analog_en(analog_en),
    .alt_out(alt_out), .alt_oe(alt_oe), .periph_in(periph_in),
    .timer16_count_capture_in(t_cc), .timer16_capture_in(t_c),
    .timer16_count_pulse(t_cnt), .timer16_capture_a_trig(t_a),
    .timer16_capture_b_trig(t_b), .ext_irq_evt(ext_evt), .key_irq_evt(key_evt),
    .twowire_ext_clock_in(tw_ck), .irq(irq)
  );

  io_board_model u_io_board_model (
    .pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .ext_val(ext_val), .ext_en(ext_en), .ck_en(ck_en), .pad_in(pad_in)
  );

  // Clock at 50 MHz.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Counts timer pulses so that one-cycle pulses are not missed; notes a high clock level.
  always @(posedge pclk) begin
    cnt_a <= cnt_clr ? 8'h00 : cnt_a + 8'(t_a);
    cnt_b <= cnt_clr ? 8'h00 : cnt_b + 8'(t_b);
    cnt_n <= cnt_clr ? 8'h00 : cnt_n + 8'(t_cnt);
    tw_hi <= cnt_clr ? 1'b0 : tw_hi | tw_ck;
  end

  // Compares each completed read or probe with the oldest expected note.
  always @(posedge pclk) begin
    if ((psel && penable && pready && !pwrite) || probe) begin
      case (probe ? probe_sel : 7)
        0: got = pad_out;
        1: got = pad_oe;
        2: got = pad_pullup;
        3: got = {56'h0, analog_en};
        4: got = {63'h0, irq};
        5: got = periph_in;
        6: got = {40'h0, cnt_n, cnt_b, cnt_a};
        8: got = {61'h0, tw_hi, t_c, t_cc};
        default: got = {31'h0, pslverr, prdata};
      endcase
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      samples_checked++;
      if (got !== ex) begin
        fail_count++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ex);
      end
    end
  end

  // One APB transfer; a read notes its expected {pslverr, prdata}.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    if (!wr)
      exp_q.push_back({31'h0, e});
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Notes an expected value and has the monitor sample one output group.
  task automatic chk(input int s, input logic [63:0] e);
    @(posedge pclk);
    exp_q.push_back(e);
    probe_sel <= s;
    probe     <= 1'b1;
    @(posedge pclk);
    probe     <= 1'b0;
  endtask

  function automatic logic [11:0] ra(input int s, input int k);
    return 12'(s * 16 + k * 4);
  endfunction

  function automatic logic [7:0] msk(input int s, input int k);
    logic [63:0] m;
    m = (k == 2) ? PULL_MASK : (k == 3) ? ALT_MASK : PIN_MASK;
    return m[s*8 +: 8];
  endfunction

  task automatic results();
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog against a hung handshake or wait.
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    results();
  end

  // Main sequence.
  initial begin
    {psel, penable, pwrite, probe, ck_en, presetn} = '0;
    {paddr, pwdata, ext_val, ext_en, alt_oe, probe_sel} = '0;
    {fail_count, samples_checked, cnt_clr, cnt_a, cnt_b} = '0;
    void'($urandom(32'h31671bac));
    alt_out = {$urandom, $urandom};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then an unmapped address.
    chk(3, 64'hff);
    for (int s = 0; s < NSLOT; s++) begin
      apb(1'b0, ra(s, 1), 0, {25'h0, PIN_MASK[s*8 +: 8]});
      apb(1'b0, ra(s, 3), 0, {25'h0, ALT_RST[s*8 +: 8]});
    end
    apb(1'b0, 12'h300, 0, {1'b1, 32'h0});
    // Random writes read back with only the existing bits.
    for (int s = 0; s < NSLOT; s++) begin
      for (int k = 0; k < 4; k++) begin
        r = $urandom;
        apb(1'b1, ra(s, k), r, '0);
        apb(1'b0, ra(s, k), 0, {25'h0, r[7:0] & msk(s, k)});
      end
    end
    // Outputs from latches; peripheral drive on port 1; open-drain port.
    v = {$urandom, $urandom};
    alt_oe <= '1;
    for (int s = 0; s < NSLOT; s++) begin
      apb(1'b1, ra(s, 0), {24'h0, v[s*8 +: 8]}, '0);
      apb(1'b1, ra(s, 1), 0, '0);
      apb(1'b1, ra(s, 3), (s == 1) ? 32'hff : 32'h0, '0);
    end
    chk(0, (v & PIN_MASK & ~64'h0000_ff00_0000_ff00) | {48'h0, alt_out[15:8], 8'h0});
    chk(1, (PIN_MASK & ~64'h0000_ff00_0000_0000) | {16'h0, ~v[47:40] & 8'h0f, 40'h0});
    alt_oe <= '0;
    // Pull-ups only on inputs of ports that have them.
    v = {$urandom, $urandom};
    for (int s = 0; s < NSLOT; s++) begin
      apb(1'b1, ra(s, 1), {24'h0, v[s*8 +: 8]}, '0);
      apb(1'b1, ra(s, 2), 32'hff, '0);
      apb(1'b1, ra(s, 3), 0, '0);
    end
    chk(2, PULL_MASK & v);
    chk(3, 64'h0);
    // Pin levels with every pin an input; the analog port then reads zero.
    v = {$urandom, $urandom};
    ext_en  <= '1;
    ext_val <= v;
    for (int s = 0; s < NSLOT; s++)
      apb(1'b1, ra(s, 1), 32'hff, '0);
    repeat (4) @(posedge pclk);
    for (int s = 0; s < NSLOT; s++)
      apb(1'b0, 12'h100 + 12'(s * 4), 0, {25'h0, v[s*8 +: 8] & PIN_MASK[s*8 +: 8]});
    apb(1'b1, ra(2, 3), 32'hff, '0);
    repeat (4) @(posedge pclk);
    chk(5, v & PIN_MASK & ~64'h0000_0000_00ff_0000);
    chk(3, 64'hff);
    // Edge events for every selection code; key pins react to falls.
    ev = 64'h000f_0000_0000_0000;
    for (int k = 0; k < NEXT; k++)
      ev[EXT_PIN[k]] = 1'b1;
    ext_val <= '0;
    for (int s = 0; s < NSLOT; s++)
      apb(1'b1, ra(s, 3), {24'h0, ev[s*8 +: 8] | ((s == 0) ? 8'h03 : 8'h00)}, '0);
    apb(1'b1, ADDR_MASK, 32'h3ff, '0);
    for (int c = 0; c < 4; c++) begin
      code = 2'(c);
      apb(1'b1, ADDR_EDGE, {20'h0, {NEXT{code}}}, '0);
      apb(1'b1, ADDR_STAT, 32'h3ff, '0);
      ext_val <= ev;
      repeat (6) @(posedge pclk);
      apb(1'b0, ADDR_STAT, 0, {27'h0, {NEXT{code[0]}}});
      chk(4, {63'h0, code[0]});
      ext_val <= '0;
      repeat (6) @(posedge pclk);
      apb(1'b0, ADDR_STAT, 0, {23'h0, 4'hf, {NEXT{|code}}});
    end
    // Mask and write-one-to-clear of the status bits.
    apb(1'b1, ADDR_MASK, 0, '0);
    chk(4, 64'h0);
    apb(1'b1, ADDR_MASK, 32'h3ff, '0);
    chk(4, 64'h1);
    apb(1'b1, ADDR_STAT, 32'h3ff, '0);
    apb(1'b0, ADDR_STAT, 0, 33'h0);
    chk(4, 64'h0);
    // Timer pins: pin B feeds capture A only, pin A feeds both.
    cnt_clr <= 1'b1;
    @(posedge pclk);
    cnt_clr <= 1'b0;
    ext_val[1] <= 1'b1;
    repeat (6) @(posedge pclk);
    ext_val[0] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(6, 64'h01_0102);
    // Small-package setup by software, then the external two-wire clock.
    apb(1'b1, ra(2, 1), 32'hc0, '0);
    apb(1'b0, ra(2, 1), 0, {25'h0, 8'hc0});
    apb(1'b1, ra(2, 0), 0, '0);
    apb(1'b1, ra(4, 1), 0, '0);
    apb(1'b1, ra(4, 0), 0, '0);
    apb(1'b1, ra(6, 1), 32'hf3, '0);
    apb(1'b1, ra(6, 0), 0, '0);
    cnt_clr <= 1'b1;
    @(posedge pclk);
    cnt_clr <= 1'b0;
    ck_en <= 1'b1;
    repeat (40) @(posedge pclk);
    ck_en <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(8, 64'h7);
    results();
  end
endmodule
